/* File: verilog/dgu_map.vh */
// Purpose: Constants for the diagnose instruction unit.
// Assumes: Parameter field numbered with bit 0 as the most significant of 16.
// Notes:   Bit n of the field is index (15-n) of a [15:0] vector.
`ifndef DGU_MAP_VH
`define DGU_MAP_VH
`define DGU_PB_FN0        7
`define DGU_PB_FN1        6
`define DGU_PB_DIR        3
`define DGU_PB_SYSID      2
`define DGU_PB_ENABLE     1
`define DGU_PB_MICRO      0
`define DGU_FN_STORAGE    2'b00
`define DGU_FN_DETECTOR   2'b01
`define DGU_FN_LOCAL      2'b10
`define DGU_FN_CHANNEL    2'b11
`define DGU_SYS_ID        16'h0A5C  // Arbitrary identification value, chosen for this block.
`define DGU_PSW_PRIV      13
`define DGU_PSW_PARITY    7
`define DGU_SEL_REGS      2'b00
`define DGU_SEL_LEVEL     2'b01
`define DGU_SEL_IADDR     2'b10
`define DGU_SEL_AKEY      2'b11
`endif

/* File: verilog/dgu_diagnose_unit.v */
// Purpose: Executes the privileged diagnose instruction for the microcoded execution unit.
// Assumes: One clock; opStart is a one-cycle pulse; storage answers in one cycle per access.
// Notes:   Register file, local store and storage array live outside; this block only steers them.
`timescale 1ns/1ns
`default_nettype none
`include "dgu_map.vh"

module dgu_diagnose_unit (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        opStart,
    input  wire [15:0] paramField,
    input  wire        problemState,
    input  wire [15:0] curReg0,
    input  wire [15:0] curReg1,
    input  wire [15:0] curReg7,
    input  wire [31:0] appendWords,
    input  wire [15:0] immedExtra,
    input  wire        isFloatReg,
    input  wire [15:0] lsReadData,
    input  wire [25:0] memReadWord,
    input  wire        procReadDone,
    input  wire        smcEvent,
    input  wire [15:0] smcInstrAddr,
    input  wire        diagModeSwitch,
    input  wire        startPressed,
    input  wire        levelBlockLoad,
    input  wire        stopAddrChange,
    input  wire        segInstrExec,
    output reg         opDone,
    output reg  [15:0] regWrData0,
    output reg  [15:0] regWrData1,
    output reg         regWrEn0,
    output reg         regWrEn1,
    output reg         memReq,
    output reg         memWrite,
    output reg  [15:0] memAddr,
    output reg  [25:0] memWriteWord,
    output reg         lsWrEn,
    output reg  [1:0]  lsClass,
    output reg  [6:0]  lsAddr,
    output reg  [31:0] lsWrData,
    output reg  [15:0] immedOut,
    output reg         immedOutValid,
    output reg         microDiagReturn,
    output reg         machineCheck,
    output reg         programCheck,
    output reg         pswParityErr,
    output reg         pswPrivErr,
    output reg         smcDetectorOn,
    output reg         stopState,
    output reg  [15:0] consoleDisplay,
    output reg         chanIntInhibit,
    output reg         cycleStealInhibit
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_MEM  = 4'b0010;
    localparam [3:0] ST_READ = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    reg  [3:0]  state_r;
    reg  [15:0] param_r;
    reg  [25:0] word_r;
    wire [1:0]  fn       = {param_r[`DGU_PB_FN0], param_r[`DGU_PB_FN1]};
    wire        enBit    = param_r[`DGU_PB_ENABLE];
    wire        dirWrite = param_r[`DGU_PB_DIR];

    // Five check bits of one byte: four Hamming parities plus overall parity.
    function [4:0] chk5;
        input [7:0] d;
        reg   [3:0] h;
        begin
            h[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
            h[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
            h[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
            h[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
            chk5 = {^{d, h}, h};
        end
    endfunction

    // Byte corrected by its syndrome flip mask; index 8 marks a double error.
    function [8:0] fix5;
        input [7:0] d;
        input [4:0] c;
        reg   [4:0] s;
        reg   [7:0] m;
        begin
            s = chk5(d) ^ c;
            // Overall parity spans the stored check bits too, so a flipped check bit reads as single.
            s[4] = ^{d, c};
            m = 8'h00;
            case (s[3:0])
                4'h3: m = 8'h01;
                4'h5: m = 8'h02;
                4'h6: m = 8'h04;
                4'h7: m = 8'h08;
                4'h9: m = 8'h10;
                4'hA: m = 8'h20;
                4'hB: m = 8'h40;
                4'hC: m = 8'h80;
                default: m = 8'h00;
            endcase
            fix5 = {(s[3:0] != 4'h0) && !s[4], d ^ m};
        end
    endfunction

    // Stored word layout: {check hi, data hi, check lo, data lo}.
    wire [8:0] fixHi = fix5(word_r[20:13], word_r[25:21]);
    wire [8:0] fixLo = fix5(word_r[7:0], word_r[12:8]);
    wire       dblErr = fixHi[8] | fixLo[8];

    // Ordinary processor reads are checked straight off the storage word.
    wire [8:0] pHi = fix5(memReadWord[20:13], memReadWord[25:21]);
    wire [8:0] pLo = fix5(memReadWord[7:0], memReadWord[12:8]);
    wire       dblErrProc = pHi[8] | pLo[8];
    wire       diagFnGo = (state_r == ST_MEM) && !param_r[`DGU_PB_SYSID] && !param_r[`DGU_PB_MICRO];
    // An enabled diagnose read is a normal read, so a double error there checks the machine too.
    wire       diagDblErr = (state_r == ST_DONE) && (fn == `DGU_FN_STORAGE) && !dirWrite && enBit && dblErr;
    wire       storeErr = (procReadDone && dblErrProc) || diagDblErr;

    // Main sequencer for one diagnose instruction.
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            param_r <= 16'h0000;
            word_r <= 26'h000_0000;
            opDone <= 1'b0;
            regWrEn0 <= 1'b0;
            regWrEn1 <= 1'b0;
            regWrData0 <= 16'h0000;
            regWrData1 <= 16'h0000;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= 16'h0000;
            memWriteWord <= 26'h000_0000;
            lsWrEn <= 1'b0;
            lsClass <= 2'b00;
            lsAddr <= 7'h00;
            lsWrData <= 32'h0000_0000;
            immedOut <= 16'h0000;
            immedOutValid <= 1'b0;
            microDiagReturn <= 1'b0;
            programCheck <= 1'b0;
            machineCheck <= 1'b0;
        end else begin
            opDone <= 1'b0;
            regWrEn0 <= 1'b0;
            regWrEn1 <= 1'b0;
            memReq <= 1'b0;
            lsWrEn <= 1'b0;
            immedOutValid <= 1'b0;
            microDiagReturn <= 1'b0;
            programCheck <= 1'b0;
            machineCheck <= storeErr;
            case (state_r)
                ST_IDLE: begin
                    if (opStart) begin
                        param_r <= paramField;
                        if (problemState) begin
                            programCheck <= 1'b1;
                            opDone <= 1'b1;
                        end else if (paramField[`DGU_PB_SYSID]) begin
                            regWrData0 <= `DGU_SYS_ID;
                            regWrEn0 <= 1'b1;
                            opDone <= 1'b1;
                        end else if (paramField[`DGU_PB_MICRO]) begin
                            microDiagReturn <= 1'b1;
                            opDone <= 1'b1;
                        end else begin
                            state_r <= ST_MEM;
                        end
                    end
                end
                ST_MEM: begin
                    state_r <= ST_DONE;
                    case (fn)
                        `DGU_FN_STORAGE: begin
                            memReq <= 1'b1;
                            memWrite <= dirWrite;
                            memAddr <= curReg7;
                            if (dirWrite) begin
                                if (enBit)
                                    memWriteWord <= {chk5(curReg1[15:8]), curReg1[15:8],
                                                     chk5(curReg1[7:0]), curReg1[7:0]};
                                else
                                    memWriteWord <= {curReg0[15:11], curReg1[15:8],
                                                     curReg0[7:3], curReg1[7:0]};
                            end else begin
                                state_r <= ST_READ;
                            end
                        end
                        `DGU_FN_LOCAL: begin
                            lsClass <= {appendWords[31], appendWords[23]};
                            lsAddr <= appendWords[30:24];
                            // Read-out waits a cycle: the local store answers the select set here.
                            if (!dirWrite) begin
                                lsWrData <= {appendWords[15:0], isFloatReg ? immedExtra : 16'h0000};
                                lsWrEn <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                ST_READ: begin
                    word_r <= memReadWord;
                    state_r <= ST_DONE;
                    opDone <= 1'b0;
                end
                ST_DONE: begin
                    if (fn == `DGU_FN_STORAGE && !dirWrite) begin
                        if (enBit) begin
                            regWrData1 <= {fixHi[7:0], fixLo[7:0]};
                            regWrEn1 <= 1'b1;
                        end else begin
                            regWrData0 <= {word_r[25:21], 3'b000, word_r[12:8], 3'b000};
                            regWrData1 <= {word_r[20:13], word_r[7:0]};
                            regWrEn0 <= 1'b1;
                            regWrEn1 <= 1'b1;
                        end
                    end
                    if (fn == `DGU_FN_LOCAL && dirWrite) begin
                        immedOut <= lsReadData;
                        immedOutValid <= 1'b1;
                    end
                    opDone <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Status flags pulse for one cycle; the status word itself is held outside this block.
    always @(posedge clk) begin
        if (sys_rst) begin
            pswParityErr <= 1'b0;
            pswPrivErr <= 1'b0;
        end else begin
            pswParityErr <= storeErr;
            pswPrivErr <= (state_r == ST_IDLE) && opStart && problemState;
        end
    end

    // Detector, stop state and console; the detector forgets only on its own reset paths.
    always @(posedge clk) begin
        if (sys_rst) begin
            smcDetectorOn <= 1'b0;
            stopState <= 1'b0;
            consoleDisplay <= 16'h0000;
        end else begin
            if (diagFnGo && fn == `DGU_FN_DETECTOR)
                smcDetectorOn <= enBit;
            if (smcEvent && smcDetectorOn && diagModeSwitch) begin
                stopState <= 1'b1;
                consoleDisplay <= smcInstrAddr;
            end else if (startPressed) begin
                stopState <= 1'b0;
            end
        end
    end

    // Channel gating; masking and stealing return by separate events.
    always @(posedge clk) begin
        if (sys_rst) begin
            chanIntInhibit <= 1'b0;
            cycleStealInhibit <= 1'b0;
        end else begin
            if (diagFnGo && fn == `DGU_FN_CHANNEL) begin
                chanIntInhibit <= !enBit;
                cycleStealInhibit <= !enBit;
            end else begin
                if ((startPressed && stopState) || levelBlockLoad)
                    chanIntInhibit <= 1'b0;
                if (stopAddrChange || segInstrExec)
                    cycleStealInhibit <= 1'b0;
            end
        end
    end

endmodule // dgu_diagnose_unit
`default_nettype wire

/* File: dv/dgu_diagnose_props.sv */
// Purpose: Port-level properties of the diagnose unit.
// Assumes: Inputs of an operation stay steady until it completes.
// Notes:   Ports are grouped per line to keep the checker short.
`timescale 1ns/1ns
`default_nettype none
`include "dgu_map.vh"
module dgu_diagnose_props (
    input wire logic        clk, sys_rst, opStart, problemState, smcEvent, diagModeSwitch,
    input wire logic        startPressed, levelBlockLoad, stopAddrChange, segInstrExec,
    input wire logic [15:0] paramField, curReg0, curReg1, curReg7, smcInstrAddr,
    input wire logic [31:0] appendWords,
    input wire logic        opDone, regWrEn0, regWrEn1, memReq, memWrite, lsWrEn, microDiagReturn,
    input wire logic        programCheck, pswPrivErr, smcDetectorOn, stopState, chanIntInhibit,
    input wire logic        cycleStealInhibit,
    input wire logic [15:0] regWrData0, memAddr, consoleDisplay,
    input wire logic [25:0] memWriteWord,
    input wire logic [1:0]  lsClass,
    input wire logic [6:0]  lsAddr
);
    logic busy_r;
    logic go;
    logic plain;
    // Starts while busy are ignored, so only an idle start may trigger a property.
    always_ff @(posedge clk) begin
        if (sys_rst || opDone) busy_r <= 1'b0;
        else if (opStart && !problemState) busy_r <= 1'b1;
    end
    // Index 2 is the identification bit, index 0 the microdiagnostic bit.
    assign go = opStart && !busy_r && !problemState;
    assign plain = go && !paramField[2] && !paramField[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    id_report_a: assert property (go && paramField[2] |=> opDone && regWrEn0 && regWrData0 == `DGU_SYS_ID)
        else $error("identification report wrong");
    priv_trap_a: assert property (opStart && !busy_r && problemState
        |=> programCheck && pswPrivErr && !regWrEn0 && !memReq) else $error("privilege trap wrong");
    micro_ret_a: assert property (go && !paramField[2] && paramField[0]
        |=> microDiagReturn && !memReq && !lsWrEn) else $error("microdiagnostic return wrong");
    mem_read_a: assert property (plain && paramField[7:6] == 2'b00 && !paramField[3]
        |-> ##2 (memReq && !memWrite && memAddr == curReg7) ##2 (opDone && regWrEn1)) else $error("read walk wrong");
    raw_write_a: assert property (plain && paramField[7:6] == 2'b00 && paramField[3:1] == 3'b100
        |-> ##2 (memReq && memWrite && memAddr == curReg7
        && memWriteWord == {curReg0[15:11], curReg1[15:8], curReg0[7:3], curReg1[7:0]}) ##1 opDone)
        else $error("raw write wrong");
    ecc_data_a: assert property (memReq && memWrite && paramField[1]
        |-> memWriteWord[20:13] == curReg1[15:8] && memWriteWord[7:0] == curReg1[7:0]) else $error("data bits wrong");
    det_clear_a: assert property ($fell(smcDetectorOn) && !$past(sys_rst) |-> $past(busy_r))
        else $error("detector cleared outside diagnose");
    ls_write_a: assert property (plain && paramField[7:6] == 2'b10 && !paramField[3]
        |-> ##[1:3] (lsWrEn && lsAddr == appendWords[30:24] && lsClass == {appendWords[31], appendWords[23]}))
        else $error("local store write wrong");
    cs_resume_a: assert property ((segInstrExec || stopAddrChange) && !busy_r |=> !cycleStealInhibit)
        else $error("cycle steal not resumed");
    mask_return_a: assert property ((levelBlockLoad || startPressed && stopState) && !busy_r |=> !chanIntInhibit)
        else $error("masking not returned");
    smc_stop_a: assert property (smcEvent && smcDetectorOn && diagModeSwitch
        |=> stopState && consoleDisplay == $past(smcInstrAddr)) else $error("stop on detection wrong");
endmodule // dgu_diagnose_props
bind dgu_diagnose_unit dgu_diagnose_props u_props (.*);
`default_nettype wire

/* File: dv/dgu_storage_model.sv */
// Purpose: Behavioural storage array and local store behind the diagnose unit.
// Assumes: Storage answers within the request cycle; sixteen words are kept.
// Notes:   The answer stands one cycle past the request, then toggles, so stale data is never trusted.
`timescale 1ns/1ns
`default_nettype none
module dgu_storage_model (
    input  wire logic        clk, memReq, memWrite,
    input  wire logic [15:0] memAddr,
    input  wire logic [25:0] memWriteWord,
    input  wire logic [1:0]  lsClass,
    input  wire logic [6:0]  lsAddr,
    output wire logic [25:0] memReadWord,
    output wire logic [15:0] lsReadData
);
    logic [25:0] store [0:15];
    logic [25:0] lastWord = 26'h000_0000;
    // whole words kept
    // The unit samples the word at the edge ending its request; a processor read looks one edge later.
    always @(posedge clk) begin
        if (memReq && memWrite) store[memAddr[3:0]] <= memWriteWord;
        lastWord <= memReq ? store[memAddr[3:0]] : ~lastWord;
    end
    assign memReadWord = memReq ? store[memAddr[3:0]] : lastWord;
    // local store read
    // Each entry reads back its own selection, so a wrong select shows up.
    assign lsReadData = {lsClass, lsAddr, 7'h2B};
endmodule // dgu_storage_model
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the diagnose unit.
// Assumes: Inputs change at the falling edge and hold while an operation runs.
// Notes:   Each scenario task drives and judges its own case.
`timescale 1ns/1ns
`default_nettype none
`include "dgu_map.vh"
`define CHK(nm, e, a) begin numChecks++; if ((e) !== (a)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module testbench;
    logic clk = 0, sys_rst = 1, opStart = 0, problemState = 0, isFloatReg = 0, procReadDone = 0, smcEvent = 0;
    logic diagModeSwitch = 0, startPressed = 0, levelBlockLoad = 0, stopAddrChange = 0, segInstrExec = 0;
    logic [15:0] paramField = 0, curReg0 = 0, curReg1 = 0, curReg7 = 0, immedExtra = 0, smcInstrAddr = 0;
    logic [31:0] appendWords = 0;
    wire logic [15:0] lsReadData, regWrData0, regWrData1, memAddr, immedOut, consoleDisplay;
    wire logic [25:0] memReadWord, memWriteWord;
    wire logic [31:0] lsWrData;
    wire logic [1:0] lsClass;
    wire logic [6:0] lsAddr;
    wire logic opDone, regWrEn0, regWrEn1, memReq, memWrite, lsWrEn, immedOutValid, microDiagReturn, machineCheck;
    wire logic programCheck, pswParityErr, pswPrivErr, smcDetectorOn, stopState, chanIntInhibit, cycleStealInhibit;
    int miscompares = 0, numChecks = 0;
    logic [15:0] r0, r1, im;
    logic [40:0] lw;
    logic [4:0] fl;
    bit inject = 0;
    dgu_diagnose_unit DUT (.*);
    dgu_storage_model storage (.*);
    // Free-running clock.
    always #10 clk = ~clk;
    task stopTest;
        if (miscompares == 0 && numChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Issues one operation and gathers write, read-out and flag pulses until two cycles after completion.
    task automatic op(input logic [15:0] p);
        int lim;
        bit done;
        bit pend;
        lim = 20;
        done = 0;
        pend = 0;
        {r0, r1, im, lw, fl} = '0;
        @(negedge clk);
        paramField = p;
        opStart = 1'b1;
        @(negedge clk);
        opStart = 1'b0;
        for (int n = 0; n < lim; n++) begin
            if (regWrEn0 === 1'b1) r0 = regWrData0;
            if (regWrEn1 === 1'b1) r1 = regWrData1;
            if (immedOutValid === 1'b1) im = immedOut;
            if (lsWrEn === 1'b1) lw = {lsClass, lsAddr, lsWrData};
            fl = fl | {microDiagReturn, machineCheck, pswParityErr, programCheck, pswPrivErr};
            if (!done && (opDone === 1'b1 || programCheck === 1'b1)) begin
                done = 1;
                lim = n + 3;
            end
            procReadDone = pend;
            pend = inject && memReq === 1'b1;
            @(negedge clk);
        end
        `CHK("op done", 1'b1, done)
    endtask
    task automatic testIdent;
        op(16'h0004);
        `CHK("id", `DGU_SYS_ID, r0)
        op(16'h00C4);
        `CHK("id over channel", {`DGU_SYS_ID, 1'b0}, {r0, chanIntInhibit})
        op(16'h0005);
        `CHK("id over micro", {`DGU_SYS_ID, 1'b0}, {r0, fl[4]})
        problemState = 1'b1;
        op(16'h0004);
        problemState = 1'b0;
        `CHK("privilege", {16'h0000, 2'b11}, {r0, fl[1:0]})
        op(16'h0001);
        `CHK("micro", {16'h0000, 1'b1}, {r0, fl[4]})
    endtask
    task automatic testStorage;
        logic [15:0] ck;
        curReg7 = 16'h0006;
        curReg1 = 16'hA53C;
        op(16'h000A);
        op(16'h0000);
        ck = r0;
        `CHK("raw data", 16'hA53C, r1)
        `CHK("zero bits", 16'h0000, r0 & 16'h0707)
        curReg0 = ck;
        curReg1 = 16'hA53D;
        op(16'h0008);
        op(16'h0002);
        `CHK("corrected", 16'hA53C, r1)
        curReg1 = 16'hA53F;
        op(16'h0008);
        inject = 1;
        op(16'h0000);
        inject = 0;
        `CHK("raw no fix", {ck, 16'hA53F}, {r0, r1})
        `CHK("double error", 2'b11, fl[3:2])
        op(16'h0002);
        `CHK("enabled double", 2'b11, fl[3:2])
    endtask
    task automatic testLocal;
        logic [6:0] a;
        logic [15:0] d;
        for (int k = 0; k < 4; k++) begin
            a = 7'h20 + 7'(k);
            d = 16'hC3A0 + 16'(k);
            isFloatReg = (k == 0);
            immedExtra = 16'h5AF0;
            appendWords = {k[1], a, k[0], a, d};
            op(16'h0080);
            `CHK("ls write", {2'(k), a, d, isFloatReg ? 16'h5AF0 : 16'h0000}, lw)
            op(16'h0088);
            `CHK("ls read", {2'(k), a, 7'h2B}, im)
        end
    endtask
    task automatic testChannel;
        op(16'h00C0);
        `CHK("inhibit", 2'b11, {chanIntInhibit, cycleStealInhibit})
        @(negedge clk) segInstrExec = 1'b1;
        @(negedge clk) segInstrExec = 1'b0;
        `CHK("steal resumed", 2'b10, {chanIntInhibit, cycleStealInhibit})
        @(negedge clk) levelBlockLoad = 1'b1;
        @(negedge clk) levelBlockLoad = 1'b0;
        `CHK("mask returned", 2'b00, {chanIntInhibit, cycleStealInhibit})
        op(16'h00C8);
        @(negedge clk) stopAddrChange = 1'b1;
        @(negedge clk) stopAddrChange = 1'b0;
        `CHK("stop address", 2'b10, {chanIntInhibit, cycleStealInhibit})
        op(16'h00C2);
        `CHK("enabled", 2'b00, {chanIntInhibit, cycleStealInhibit})
    endtask
    task automatic testDetector;
        op(16'h004A);
        `CHK("detector set", 1'b1, smcDetectorOn)
        @(negedge clk) {startPressed, levelBlockLoad, segInstrExec, stopAddrChange} = 4'hF;
        @(negedge clk) {startPressed, levelBlockLoad, segInstrExec, stopAddrChange} = 4'h0;
        `CHK("detector kept", 1'b1, smcDetectorOn)
        op(16'h0040);
        `CHK("detector reset", 1'b0, smcDetectorOn)
        op(16'h0042);
        diagModeSwitch = 1'b1;
        smcInstrAddr = 16'h1234;
        @(negedge clk) smcEvent = 1'b1;
        @(negedge clk) smcEvent = 1'b0;
        `CHK("stop display", {1'b1, 16'h1234}, {stopState, consoleDisplay})
        op(16'h00C0);
        @(negedge clk) startPressed = 1'b1;
        @(negedge clk) startPressed = 1'b0;
        `CHK("start in stop", 3'b001, {stopState, chanIntInhibit, cycleStealInhibit})
    endtask
    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        `CHK("reset levels", 4'h0, {smcDetectorOn, stopState, chanIntInhibit, cycleStealInhibit})
        testIdent;
        testStorage;
        testLocal;
        testChannel;
        testDetector;
        stopTest;
    end
    // The whole run needs well under a tenth of this span.
    initial begin
        #200000;
        miscompares++;
        stopTest;
    end
endmodule // testbench
`default_nettype wire
